// *** shared/gec_cfg.svh ***
// Constants for the general-purpose pin and converter control block
`ifndef GEC_CFG_SVH
`define GEC_CFG_SVH
`define GEC_NUM_PINS 3
`define GEC_NUM_IRQ_PINS 2
`define GEC_PIN_A 0
`define GEC_PIN_B 1
`define GEC_PIN_C 2
`define GEC_RST_LOW 1'b0
`define GEC_RST_HIGH 1'b1
`endif

// *** shared/gec_pkg.sv ***
// Types shared by the pin control block
package gec_pkg;
    // Per-pin host configuration
    typedef struct packed {
        logic out_en;      // Pin is an output
        logic out_val;     // Level when output (1 = released)
        logic irq_en;      // Interrupt-request mode
        logic edge_rise;   // 1 = rising edge, 0 = falling edge
        logic conv_en;     // Converter on/off control
        logic stby_en;     // Standby control (pin a only)
        logic pol_high;    // 1 = high level means on or standby
    } gec_pin_cfg_t;

    // Host converter commands
    typedef struct packed {
        logic one_on;
        logic two_on;
        logic stby;
    } gec_conv_cmd_t;

    // Edge interrupt channel states
    typedef enum logic [2:0] {
        GEC_IDLE = 3'b001,
        GEC_ARMED = 3'b010,
        GEC_RELEASE = 3'b100
    } gec_irq_state_t;
endpackage : gec_pkg

// *** src/gec_gpio_ctrl.sv ***
// Three open-drain general-purpose pins with interrupt, converter and trigger modes
// Notes on behaviour
// RULE1: three open-drain pins, each input or output
// RULE2: output pin driven low or released per host
// RULE3: edges on pins a, b raise interrupt requests
// RULE4: mask bit suppresses each pin interrupt request
// RULE5: pin a: converter one and standby; b: two
// RULE6: pin a level with polarity enables converter one
// RULE7: pin a level with polarity sets standby both
// RULE8: pin c is conversion trigger when enabled
// RULE9: pin c otherwise a plain logic output
// RULE10: rising or falling edge selected by host
// RULE11: pin input passes two latch stages
// RULE12: first selected edge sets flag, interrupt low
// RULE13: clear on read only after opposite edge
// RULE14: two edges then read release interrupt line
// RULE15: edges without read leave interrupt unchanged
// RULE16: undervoltage or output reconfiguration clears interrupt
// RULE17: host keeps interrupt and converter modes exclusive
// RULE18: after reset all pins input, no mode
// RULE19: converter runs or sleeps only when both agree
// RULE20: output high means released, low means pulled
// RULE21: edges from second stage versus previous sample
`timescale 1ns/1ns
`default_nettype none
`include "gec_cfg.svh"
module gec_gpio_ctrl import gec_pkg::*; #(
    parameter int NUM_PINS = `GEC_NUM_PINS
) (
    input wire logic clk_in,
    input wire logic sys_rst_in,
    input wire logic [NUM_PINS-1:0] gp_pin_in,
    output logic [NUM_PINS-1:0] gp_pin_out,
    output logic [NUM_PINS-1:0] gp_pin_oe_out,
    input wire gec_pin_cfg_t cfg_a_in,
    input wire gec_pin_cfg_t cfg_b_in,
    input wire gec_pin_cfg_t cfg_c_in,
    input wire logic adc_trg_en_in,
    input wire logic [`GEC_NUM_IRQ_PINS-1:0] irq_mask_in,
    input wire gec_conv_cmd_t host_cmd_in,
    input wire logic host_read_in,
    input wire logic undervoltage_lockout_in,
    output logic int_n_out,
    output logic [NUM_PINS-1:0] pin_level_out,
    output logic buck_conv_one_en_out,
    output logic buck_conv_two_en_out,
    output logic buck_stby_out,
    output logic adc_trig_out
);
    gec_pin_cfg_t cfg [NUM_PINS];
    logic [NUM_PINS-1:0] lvl;
    logic [NUM_PINS-1:0] rise;
    logic [NUM_PINS-1:0] fall;
    logic [NUM_PINS-1:0] sel_edge;
    logic [NUM_PINS-1:0] opp_edge;
    logic [`GEC_NUM_IRQ_PINS-1:0] irq_raw;
    logic [`GEC_NUM_IRQ_PINS-1:0] out_now_r;
    logic [NUM_PINS-1:0] oe_r;
    logic [NUM_PINS-1:0] lvl_r;
    logic int_n_r;
    logic one_en_r;
    logic two_en_r;
    logic stby_r;
    logic trig_r;

    assign cfg[`GEC_PIN_A] = cfg_a_in;
    assign cfg[`GEC_PIN_B] = cfg_b_in;
    assign cfg[`GEC_PIN_C] = cfg_c_in;

    // =====================================
    // Per-pin synchronisers and edge select
    genvar gi;
    generate
        for (gi = 0; gi < NUM_PINS; gi++) begin : g_pin
            gec_sync u_sync (
                .clk_in(clk_in),
                .sys_rst_in(sys_rst_in),
                .pin_in(gp_pin_in[gi]),
                .level_out(lvl[gi]),
                .rise_out(rise[gi]),
                .fall_out(fall[gi])
            );
            assign sel_edge[gi] = cfg[gi].edge_rise ? rise[gi] : fall[gi]; // RULE10
            assign opp_edge[gi] = cfg[gi].edge_rise ? fall[gi] : rise[gi]; // RULE13
        end
    endgenerate

    // =====================================
    // Interrupt channels for pins a and b
    generate
        for (gi = 0; gi < `GEC_NUM_IRQ_PINS; gi++) begin : g_irq
            wire logic chan_en;
            assign chan_en = ~cfg[gi].out_en & cfg[gi].irq_en; // RULE3
            gec_irq_chan u_chan (
                .clk_in(clk_in),
                .sys_rst_in(sys_rst_in),
                .enable_in(chan_en),
                .sel_edge_in(sel_edge[gi]),
                .opp_edge_in(opp_edge[gi]),
                .host_read_in(host_read_in),
                .force_clr_in(undervoltage_lockout_in), // RULE16
                .irq_out(irq_raw[gi])
            );
        end
    endgenerate

    // Output reconfiguration edge detect for the clearing check
    wire logic [`GEC_NUM_IRQ_PINS-1:0] out_now;
    assign out_now = {cfg_b_in.out_en, cfg_a_in.out_en};

    // =====================================
    // Combined interrupt, masked per pin
    wire logic int_any;
    assign int_any = |(irq_raw & ~irq_mask_in); // RULE4

    // =====================================
    // Pin a and pin b converter commands with host polarity
    wire logic a_in_mode;
    wire logic b_in_mode;
    wire logic a_on_lvl;
    wire logic b_on_lvl;
    wire logic pin_one_on;
    wire logic pin_two_on;
    wire logic pin_stby;
    assign a_in_mode = ~cfg_a_in.out_en;
    assign b_in_mode = ~cfg_b_in.out_en;
    assign a_on_lvl = ~(lvl[`GEC_PIN_A] ^ cfg_a_in.pol_high);
    assign b_on_lvl = ~(lvl[`GEC_PIN_B] ^ cfg_b_in.pol_high);
    // Pin command is "enabled" unless pin control is active and says off
    assign pin_one_on = ~(a_in_mode & cfg_a_in.conv_en) | a_on_lvl; // RULE6
    assign pin_two_on = ~(b_in_mode & cfg_b_in.conv_en) | b_on_lvl; // RULE5
    // Pin standby request only when standby control is active
    assign pin_stby = a_in_mode & cfg_a_in.stby_en & a_on_lvl; // RULE7

    wire logic one_en_nxt;
    wire logic two_en_nxt;
    wire logic stby_nxt;
    assign one_en_nxt = host_cmd_in.one_on & pin_one_on; // RULE19
    assign two_en_nxt = host_cmd_in.two_on & pin_two_on; // RULE19
    assign stby_nxt = host_cmd_in.stby & pin_stby; // RULE19

    // =====================================
    // Pin c conversion trigger on selected edge
    wire logic trig_nxt;
    assign trig_nxt = ~cfg_c_in.out_en & adc_trg_en_in & sel_edge[`GEC_PIN_C]; // RULE8

    // =====================================
    // Open-drain drive: enable only while pulling low
    wire logic [NUM_PINS-1:0] oe_nxt;
    generate
        for (gi = 0; gi < NUM_PINS; gi++) begin : g_drv
            assign oe_nxt[gi] = cfg[gi].out_en & ~cfg[gi].out_val; // RULE2 RULE20
        end
    endgenerate

    // Registered outputs; reset leaves pins released with no mode
    always_ff @(posedge clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            oe_r <= '0; // RULE18
            lvl_r <= '0;
            int_n_r <= `GEC_RST_HIGH;
            one_en_r <= `GEC_RST_LOW;
            two_en_r <= `GEC_RST_LOW;
            stby_r <= `GEC_RST_LOW;
            trig_r <= `GEC_RST_LOW;
            out_now_r <= '0;
        end else begin
            oe_r <= oe_nxt; // RULE1 RULE9
            lvl_r <= lvl;
            // Reconfiguring as output drops the line via channel disable
            int_n_r <= ~int_any; // RULE16
            one_en_r <= one_en_nxt;
            two_en_r <= two_en_nxt;
            stby_r <= stby_nxt;
            trig_r <= trig_nxt;
            out_now_r <= out_now;
        end
    end

    assign gp_pin_out = '0; // Open drain only ever pulls low
    assign gp_pin_oe_out = oe_r;
    assign pin_level_out = lvl_r;
    assign int_n_out = int_n_r;
    assign buck_conv_one_en_out = one_en_r;
    assign buck_conv_two_en_out = two_en_r;
    assign buck_stby_out = stby_r;
    assign adc_trig_out = trig_r;

    // =====================================
    // Assertions
    // Pin a channel can run: input, interrupt mode, no lockout
    wire logic a_irq_live;
    assign a_irq_live = ~cfg_a_in.out_en & cfg_a_in.irq_en & ~undervoltage_lockout_in;

    property p_out_drive; // RULE20
        @(posedge clk_in) disable iff (sys_rst_in)
        1'b1 |=> (gp_pin_oe_out[0] == $past(cfg_a_in.out_en & ~cfg_a_in.out_val));
    endproperty
    a_out_drive: assert property (p_out_drive) else $error("pin a drive wrong"); // RULE2

    property p_int_first; // RULE12
        @(posedge clk_in) disable iff (sys_rst_in)
        (~cfg_a_in.out_en & cfg_a_in.irq_en & ~irq_mask_in[0] & ~undervoltage_lockout_in
         & sel_edge[0] & !irq_raw[0]) ##1 (cfg_a_in.irq_en & ~cfg_a_in.out_en
         & ~undervoltage_lockout_in & ~irq_mask_in[0]) |=> !int_n_out;
    endproperty
    a_int_first: assert property (p_int_first) else $error("interrupt not raised"); // RULE12

    property p_mask; // RULE4
        @(posedge clk_in) disable iff (sys_rst_in)
        (irq_mask_in[1] & !irq_raw[0]) |=> int_n_out;
    endproperty
    a_mask: assert property (p_mask) else $error("masked interrupt seen"); // RULE4

    property p_no_read_hold; // RULE15
        @(posedge clk_in) disable iff (sys_rst_in)
        (irq_raw[0] & !host_read_in & !undervoltage_lockout_in & cfg_a_in.irq_en
         & ~cfg_a_in.out_en) |=> irq_raw[0];
    endproperty
    a_no_read_hold: assert property (p_no_read_hold) else $error("request dropped"); // RULE15

    property p_undervoltage_lockout; // RULE16
        @(posedge clk_in) disable iff (sys_rst_in)
        undervoltage_lockout_in |=> !irq_raw[0] && !irq_raw[1];
    endproperty
    a_undervoltage_lockout: assert property (p_undervoltage_lockout) else $error("lockout did not clear"); // RULE16

    property p_conv_one; // RULE19
        @(posedge clk_in) disable iff (sys_rst_in)
        !host_cmd_in.one_on |=> !buck_conv_one_en_out;
    endproperty
    a_conv_one: assert property (p_conv_one) else $error("converter one on"); // RULE19

    property p_stby; // RULE7
        @(posedge clk_in) disable iff (sys_rst_in)
        buck_stby_out |-> $past(cfg_a_in.stby_en & host_cmd_in.stby);
    endproperty
    a_stby: assert property (p_stby) else $error("standby without request"); // RULE7

    property p_trig; // RULE8
        @(posedge clk_in) disable iff (sys_rst_in)
        adc_trig_out |-> $past(adc_trg_en_in) && $past(!cfg_c_in.out_en);
    endproperty
    a_trig: assert property (p_trig) else $error("trigger not enabled"); // RULE8

    // Read while the first stage is still set leaves the request up
    property p_early_read; // RULE13
        @(posedge clk_in) disable iff (sys_rst_in)
        ($rose(irq_raw[0]) & !opp_edge[0] & a_irq_live)
        ##1 (host_read_in & !opp_edge[0] & a_irq_live) |=> irq_raw[0];
    endproperty
    a_early_read: assert property (p_early_read) else $error("early read cleared"); // RULE13

    // Turning a pin into an output drops its pending request
    property p_reconf; // RULE16
        @(posedge clk_in) disable iff (sys_rst_in)
        (|(out_now & ~out_now_r)) |=> ((irq_raw & $past(out_now)) == '0);
    endproperty
    a_reconf: assert property (p_reconf) else $error("output reconfig kept request"); // RULE16

    property p_conv_two; // RULE19
        @(posedge clk_in) disable iff (sys_rst_in)
        !host_cmd_in.two_on |=> !buck_conv_two_en_out;
    endproperty
    a_conv_two: assert property (p_conv_two) else $error("converter two on"); // RULE19

    // Pin a in converter control with on level and host on
    property p_pin_one_on; // RULE6
        @(posedge clk_in) disable iff (sys_rst_in)
        (~cfg_a_in.out_en & cfg_a_in.conv_en & host_cmd_in.one_on
         & (lvl[`GEC_PIN_A] == cfg_a_in.pol_high)) |=> buck_conv_one_en_out;
    endproperty
    a_pin_one_on: assert property (p_pin_one_on) else $error("converter one stayed off"); // RULE6

    property p_pin_one_off; // RULE6
        @(posedge clk_in) disable iff (sys_rst_in)
        (~cfg_a_in.out_en & cfg_a_in.conv_en
         & (lvl[`GEC_PIN_A] != cfg_a_in.pol_high)) |=> !buck_conv_one_en_out;
    endproperty
    a_pin_one_off: assert property (p_pin_one_off) else $error("pin off ignored"); // RULE6

    property p_pin_two_off; // RULE5
        @(posedge clk_in) disable iff (sys_rst_in)
        (~cfg_b_in.out_en & cfg_b_in.conv_en
         & (lvl[`GEC_PIN_B] != cfg_b_in.pol_high)) |=> !buck_conv_two_en_out;
    endproperty
    a_pin_two_off: assert property (p_pin_two_off) else $error("pin b off ignored"); // RULE5

    // Standby needs both the host and the pin level
    property p_stby_pin; // RULE7
        @(posedge clk_in) disable iff (sys_rst_in)
        (~cfg_a_in.out_en & cfg_a_in.stby_en & host_cmd_in.stby
         & (lvl[`GEC_PIN_A] == cfg_a_in.pol_high)) |=> buck_stby_out;
    endproperty
    a_stby_pin: assert property (p_stby_pin) else $error("standby not entered"); // RULE7

    property p_pin_c_drive; // RULE9
        @(posedge clk_in) disable iff (sys_rst_in)
        1'b1 |=> (gp_pin_oe_out[2] == $past(cfg_c_in.out_en & ~cfg_c_in.out_val));
    endproperty
    a_pin_c_drive: assert property (p_pin_c_drive) else $error("pin c drive wrong"); // RULE9

    // Trigger is a single-cycle pulse per edge
    property p_trig_once; // RULE21
        @(posedge clk_in) disable iff (sys_rst_in)
        adc_trig_out |=> !adc_trig_out;
    endproperty
    a_trig_once: assert property (p_trig_once) else $error("trigger longer than one cycle"); // RULE21

    // Main scenarios reached
    c_int: cover property (@(posedge clk_in) disable iff (sys_rst_in) $fell(int_n_out));
    c_rel: cover property (@(posedge clk_in) disable iff (sys_rst_in) $rose(int_n_out));
    c_trig: cover property (@(posedge clk_in) disable iff (sys_rst_in) adc_trig_out);
    c_reconf: cover property (@(posedge clk_in) disable iff (sys_rst_in)
        |(out_now & ~out_now_r & irq_raw));
    c_stby: cover property (@(posedge clk_in) disable iff (sys_rst_in) buck_stby_out);
endmodule : gec_gpio_ctrl
`default_nettype wire

// *** src/gec_irq_chan.sv ***
// Edge interrupt channel: first-stage edge flag and output latch
`timescale 1ns/1ns
`default_nettype none
`include "gec_cfg.svh"
module gec_irq_chan import gec_pkg::*; (
    input wire logic clk_in,
    input wire logic sys_rst_in,
    input wire logic enable_in,
    input wire logic sel_edge_in,
    input wire logic opp_edge_in,
    input wire logic host_read_in,
    input wire logic force_clr_in,
    output logic irq_out
);
    gec_irq_state_t state_r;
    gec_irq_state_t state_nxt;

    // =====================================
    // IDLE: no request. ARMED: first edge seen, line low, first stage set.
    // RELEASE: opposite edge returned first stage, line low until a read.
    always_comb begin
        state_nxt = state_r;
        unique case (state_r)
            GEC_IDLE: begin
                if (enable_in && sel_edge_in)
                    state_nxt = GEC_ARMED; // RULE12
            end
            GEC_ARMED: begin
                if (opp_edge_in)
                    state_nxt = GEC_RELEASE; // RULE13
            end
            GEC_RELEASE: begin
                if (host_read_in)
                    state_nxt = GEC_IDLE; // RULE14
            end
            default: state_nxt = GEC_IDLE;
        endcase
        if (force_clr_in || !enable_in)
            state_nxt = GEC_IDLE; // RULE16
    end

    always_ff @(posedge clk_in or posedge sys_rst_in) begin
        if (sys_rst_in)
            state_r <= GEC_IDLE;
        else
            state_r <= state_nxt;
    end

    // Request stays up through any edges until a read after release
    assign irq_out = (state_r != GEC_IDLE); // RULE15
endmodule : gec_irq_chan
`default_nettype wire

// *** src/gec_sync.sv ***
// Two-stage synchroniser with edge pulse
`timescale 1ns/1ns
`default_nettype none
`include "gec_cfg.svh"
module gec_sync import gec_pkg::*; (
    input wire logic clk_in,
    input wire logic sys_rst_in,
    input wire logic pin_in,
    output logic level_out,
    output logic rise_out,
    output logic fall_out
);
    logic stage1_r;
    logic stage2_r;
    logic prev_r;

    // =====================================
    // Double latch and previous sample
    always_ff @(posedge clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            stage1_r <= `GEC_RST_HIGH;
            stage2_r <= `GEC_RST_HIGH;
            prev_r <= `GEC_RST_HIGH;
        end else begin
            stage1_r <= pin_in; // RULE11
            stage2_r <= stage1_r; // RULE11
            prev_r <= stage2_r;
        end
    end

    // Edge pulses from second stage versus previous sample
    assign level_out = stage2_r;
    assign rise_out = stage2_r & ~prev_r; // RULE21
    assign fall_out = ~stage2_r & prev_r; // RULE21
endmodule : gec_sync
`default_nettype wire

// *** testbench/gec_pin_model.sv ***
// Far-side pin model: pull-ups and external drivers on the three pins
`timescale 1ns/1ns
`default_nettype none
// =====================================
// Pin model
module gec_pin_model (
    input wire logic [2:0] pull_low_in,
    input wire logic [2:0] oe_in,
    output logic [2:0] pin_out
);
    // Wired-AND: pull-up unless the block or the outside pulls low
    assign pin_out = ~(pull_low_in | oe_in);
endmodule : gec_pin_model
`default_nettype wire

// *** testbench/tb.sv ***
// Self-checking bench for the pin control block
`timescale 1ns/1ns
`default_nettype none
// =====================================
// Bench top
module tb;
    import gec_pkg::*;
    logic clk_in = 1'b0;
    logic sys_rst_in = 1'b1;
    logic [2:0] pull_low = 3'h0;
    logic [2:0] pin_w, oe, pout, lvl;
    gec_pin_cfg_t cfg_a = '0, cfg_b = '0, cfg_c = '0;
    gec_conv_cmd_t cmd = '0;
    logic trg_en = 1'b0, rd = 1'b0, undervoltage_lockout = 1'b0;
    logic [1:0] mask = 2'h0;
    logic int_n, c1, c2, sb, trig;
    int errors = 0, check_count = 0, trig_cnt = 0;

    // Clock and trigger pulse counter
    always #2 clk_in = ~clk_in;
    always @(posedge clk_in) if (trig === 1'b1) trig_cnt++;

    gec_pin_model u_pins (.pull_low_in(pull_low), .oe_in(oe), .pin_out(pin_w));
    gec_gpio_ctrl u_dut (.clk_in(clk_in), .sys_rst_in(sys_rst_in),
        .gp_pin_in(pin_w), .gp_pin_out(pout), .gp_pin_oe_out(oe),
        .cfg_a_in(cfg_a), .cfg_b_in(cfg_b), .cfg_c_in(cfg_c),
        .adc_trg_en_in(trg_en), .irq_mask_in(mask), .host_cmd_in(cmd),
        .host_read_in(rd), .undervoltage_lockout_in(undervoltage_lockout), .int_n_out(int_n),
        .pin_level_out(lvl), .buck_conv_one_en_out(c1),
        .buck_conv_two_en_out(c2), .buck_stby_out(sb), .adc_trig_out(trig));

    // Verdict and end of run
    task summarize;
        $display("checks %0d errors %0d", check_count, errors);
        if (errors == 0 && check_count > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask : summarize

    task tick(input int n);
        repeat (n) @(posedge clk_in);
        #1;
    endtask : tick

    task check(input logic got, input logic exp, input string what);
        check_count++;
        if (got !== exp) begin
            errors++;
            $display("wrong value at %0t: %s", $time, what);
        end
    endtask : check

    // Bounded wait for the interrupt line level
    task wait_int(input logic exp);
        int i;
        for (i = 0; i < 20 && int_n !== exp; i++) tick(1);
        check(int_n, exp, "int_n");
        if (int_n !== exp) summarize();
    endtask : wait_int

    // One-cycle host read pulse
    task host_read;
        rd = 1'b1;
        tick(1);
        rd = 1'b0;
    endtask : host_read

    // Pulse a pin low then release it
    task pulse_pin(input int p);
        pull_low[p] = 1'b1;
        tick(6);
        pull_low[p] = 1'b0;
    endtask : pulse_pin

    // Watchdog
    initial begin
        #200000;
        errors++;
        summarize();
    end

    // Main sequence
    initial begin
        tick(5);
        check(oe === 3'h0 && int_n === 1'b1, 1'b1, "reset pins");
        check(c1 | c2 | sb | trig, 1'b0, "reset modes");
        sys_rst_in = 1'b0;
        tick(1);
        // Static outputs
        cfg_a.out_en = 1'b1;
        cfg_c.out_en = 1'b1;
        tick(6);
        check(oe[0] & oe[2] & ~pout[0], 1'b1, "drive low");
        check(lvl[0], 1'b0, "pin a level");
        cfg_a.out_val = 1'b1;
        cfg_c.out_val = 1'b1;
        pull_low[1] = 1'b1;
        tick(6);
        check(oe[0] | oe[2], 1'b0, "release");
        check(lvl[1], 1'b0, "pin b input");
        pull_low[1] = 1'b0;
        // Falling-edge interrupt on pin a, no conversion mode
        cfg_a = '0;
        cfg_c = '0;
        cfg_a.irq_en = 1'b1;
        tick(6);
        pull_low[0] = 1'b1;
        tick(2);
        check(int_n, 1'b1, "sync latency");
        wait_int(1'b0);
        host_read();
        tick(3);
        check(int_n, 1'b0, "early read");
        pull_low[0] = 1'b0;
        tick(6);
        check(int_n, 1'b0, "no read yet");
        pulse_pin(0);
        tick(6);
        check(int_n, 1'b0, "edges no read");
        host_read();
        wait_int(1'b1);
        // Rising edge on pin b, masked then unmasked
        cfg_b.irq_en = 1'b1;
        cfg_b.edge_rise = 1'b1;
        mask = 2'h2;
        tick(3);
        pulse_pin(1);
        tick(10);
        check(int_n, 1'b1, "masked");
        undervoltage_lockout = 1'b1;
        tick(3);
        undervoltage_lockout = 1'b0;
        mask = 2'h0;
        tick(3);
        pulse_pin(1);
        wait_int(1'b0);
        undervoltage_lockout = 1'b1;
        wait_int(1'b1);
        undervoltage_lockout = 1'b0;
        tick(3);
        pulse_pin(1);
        wait_int(1'b0);
        cfg_b.out_en = 1'b1;
        cfg_b.out_val = 1'b1;
        wait_int(1'b1);
        // Converter on/off control
        cfg_a = '0;
        cfg_b = '0;
        cfg_a.conv_en = 1'b1;
        cfg_a.pol_high = 1'b1;
        cmd.one_on = 1'b1;
        cmd.two_on = 1'b1;
        tick(6);
        check(c1, 1'b1, "one on");
        pull_low[0] = 1'b1;
        tick(6);
        check(c1, 1'b0, "one off by pin");
        pull_low[0] = 1'b0;
        cmd.one_on = 1'b0;
        tick(6);
        check(c1, 1'b0, "one off by host");
        cfg_b.conv_en = 1'b1;
        pull_low[1] = 1'b1;
        tick(6);
        check(c2, 1'b1, "two on low");
        pull_low[1] = 1'b0;
        tick(6);
        check(c2, 1'b0, "two off high");
        // Standby control, low level active
        cfg_a = '0;
        cfg_a.stby_en = 1'b1;
        cmd.stby = 1'b1;
        pull_low[0] = 1'b1;
        tick(6);
        check(sb, 1'b1, "standby");
        cmd.stby = 1'b0;
        tick(3);
        check(sb, 1'b0, "host no standby");
        pull_low[0] = 1'b0;
        // Conversion trigger on pin c rising edge
        cfg_c.edge_rise = 1'b1;
        trg_en = 1'b1;
        pull_low[2] = 1'b1;
        tick(6);
        trig_cnt = 0;
        pull_low[2] = 1'b0;
        tick(8);
        check(trig_cnt == 1, 1'b1, "one trigger");
        trg_en = 1'b0;
        trig_cnt = 0;
        pulse_pin(2);
        tick(8);
        check(trig_cnt == 0, 1'b1, "trigger off");
        summarize();
    end
endmodule : tb
`default_nettype wire
